//--- urr_device.sv
// Memory interface end of the user reset request handshake.
// Assumes CLOCK is the core clock; the request may arrive asynchronously.
`timescale 1ns/1ps
`include "urr_defines.svh"
module urr_device
  import urr_pkg::*;
#(
  parameter int CAL_CYC = `URR_CAL_CYC,
  parameter int SEQ_CYC = `URR_SEQ_CYC,
  parameter int START_DLY_CYC = `URR_START_DLY_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  urr_if.device LINK,
  input wire logic CAL_PASS_IN,
  output logic CAL_SUCCESS,
  output logic CAL_FAIL
);
  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic prev_reg, prev_next;
  urr_dev_state_t state_reg, state_next;
  urr_cnt_t cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic crst_n_reg, crst_n_next;
  logic arst_n_reg, arst_n_next;
  logic succ_reg, succ_next;
  logic fail_reg, fail_next;
  logic fall;

  // The first stage feeds only the second, so metastability stays contained.
  always_comb begin
    sync1_next = LINK.reset_req;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
    end
  end

  // Only the high-to-low edge counts, so a level held high never triggers.
  assign fall = prev_reg & ~sync2_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = done_reg;
    crst_n_next = crst_n_reg;
    arst_n_next = arst_n_reg;
    succ_next = succ_reg;
    fail_next = fail_reg;
    case (state_reg)
      URR_DEV_CAL: begin
        crst_n_next = 1'b0;
        arst_n_next = 1'b0;
        if (cnt_reg == urr_cnt_t'(CAL_CYC - 1)) begin
          done_next = 1'b1;
          crst_n_next = 1'b1;
          arst_n_next = 1'b1;
          succ_next = CAL_PASS_IN;
          fail_next = ~CAL_PASS_IN;
          cnt_next = '0;
          state_next = URR_DEV_READY;
        end else begin
          cnt_next = cnt_reg + urr_cnt_t'(1);
        end
      end
      URR_DEV_READY: begin
        // Done only falls here, on a completed request pulse.
        if (fall) begin
          done_next = 1'b0;
          cnt_next = '0;
          state_next = URR_DEV_WAIT;
        end
      end
      URR_DEV_WAIT: begin
        // Stands in for the manager's scan latency, which is not fixed in practice.
        if (cnt_reg == urr_cnt_t'(START_DLY_CYC - 1)) begin
          cnt_next = '0;
          crst_n_next = 1'b0;
          arst_n_next = 1'b0;
          succ_next = 1'b0;
          fail_next = 1'b0;
          state_next = URR_DEV_SEQ;
        end else begin
          cnt_next = cnt_reg + urr_cnt_t'(1);
        end
      end
      URR_DEV_SEQ: begin
        // Falling edges here are dropped, the state does not look at them.
        if (cnt_reg == urr_cnt_t'(SEQ_CYC - 1)) begin
          cnt_next = '0;
          crst_n_next = 1'b1;
          arst_n_next = 1'b1;
          succ_next = CAL_PASS_IN;
          fail_next = ~CAL_PASS_IN;
          done_next = 1'b1;
          state_next = URR_DEV_READY;
        end else begin
          cnt_next = cnt_reg + urr_cnt_t'(1);
        end
      end
      default: begin
        state_next = URR_DEV_CAL;
        cnt_next = '0;
        done_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= URR_DEV_CAL;
      cnt_reg <= '0;
      done_reg <= `URR_DONE_RST;
      crst_n_reg <= `URR_CORE_RST_N_RST;
      arst_n_reg <= `URR_CORE_RST_N_RST;
      succ_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      crst_n_reg <= crst_n_next;
      arst_n_reg <= arst_n_next;
      succ_reg <= succ_next;
      fail_reg <= fail_next;
    end
  end

  assign LINK.reset_done = done_reg;
  assign LINK.core_reset_n = crst_n_reg;
  assign LINK.afi_reset_n = arst_n_reg;
  assign CAL_SUCCESS = succ_reg;
  assign CAL_FAIL = fail_reg;
endmodule // urr_device

//--- urr_defines.svh
// Constants for the user reset request handshake.
// Assumes inclusion by bare name from the same folder.
`ifndef URR_DEFINES_SVH
`define URR_DEFINES_SVH
`define URR_MIN_PULSE_CYC 2
`define URR_CAL_CYC 16
`define URR_SEQ_CYC 32
`define URR_START_DLY_CYC 4
`define URR_CNT_W 8
`define URR_DONE_RST 1'b0
`define URR_CORE_RST_N_RST 1'b0
`endif

//--- urr_pkg.sv
// Types shared by both ends of the user reset request handshake.
// Assumes urr_defines.svh sits in the same folder.
`include "urr_defines.svh"
package urr_pkg;
  typedef enum logic [3:0] {
    URR_DEV_CAL = 4'h1,
    URR_DEV_READY = 4'h2,
    URR_DEV_WAIT = 4'h4,
    URR_DEV_SEQ = 4'h8
  } urr_dev_state_t;
  typedef enum logic [3:0] {
    URR_USR_IDLE = 4'h1,
    URR_USR_HIGH = 4'h2,
    URR_USR_WLOW = 4'h4,
    URR_USR_WHIGH = 4'h8
  } urr_usr_state_t;
  typedef logic [`URR_CNT_W-1:0] urr_cnt_t;
endpackage

//--- urr_if.sv
// Interface joining user logic and the memory interface reset handshake.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface urr_if;
  logic reset_req;
  logic reset_done;
  logic core_reset_n;
  logic afi_reset_n;
  modport device (input reset_req, output reset_done, output core_reset_n, output afi_reset_n);
  modport user (output reset_req, input reset_done, input core_reset_n, input afi_reset_n);
endinterface

//--- urr_user.sv
// User logic end of the reset request handshake.
// Assumes same core clock as the device; its state is never reset by core resets.
`timescale 1ns/1ps
`include "urr_defines.svh"
module urr_user
  import urr_pkg::*;
#(
  parameter int PULSE_CYC = `URR_MIN_PULSE_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  urr_if.user LINK,
  input wire logic START,
  input wire logic OTHERS_DONE,
  output logic BUSY,
  output logic DONE_SEEN
);
  urr_usr_state_t state_reg, state_next;
  urr_cnt_t cnt_reg, cnt_next;
  logic req_reg, req_next;
  logic done_s_reg, done_s_next;
  logic busy_reg, busy_next;
  logic seen_reg, seen_next;

  // Sampled by flops on RST_N only, never by the core resets.
  always_comb begin
    done_s_next = LINK.reset_done;
    state_next = state_reg;
    cnt_next = cnt_reg;
    req_next = req_reg;
    busy_next = busy_reg;
    seen_next = 1'b0;
    case (state_reg)
      URR_USR_IDLE: begin
        busy_next = 1'b0;
        if (START && done_s_reg && OTHERS_DONE) begin
          req_next = 1'b1;
          busy_next = 1'b1;
          cnt_next = '0;
          state_next = URR_USR_HIGH;
        end
      end
      URR_USR_HIGH: begin
        // One extra cycle covers the device's synchroniser margin.
        if (cnt_reg == urr_cnt_t'(PULSE_CYC)) begin
          req_next = 1'b0;
          state_next = URR_USR_WLOW;
        end else begin
          cnt_next = cnt_reg + urr_cnt_t'(1);
        end
      end
      URR_USR_WLOW: begin
        if (!done_s_reg) begin
          state_next = URR_USR_WHIGH;
        end
      end
      URR_USR_WHIGH: begin
        // Done high only ends the sequence; calibration status is read elsewhere.
        if (done_s_reg) begin
          seen_next = 1'b1;
          busy_next = 1'b0;
          state_next = URR_USR_IDLE;
        end
      end
      default: begin
        state_next = URR_USR_IDLE;
        req_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= URR_USR_IDLE;
      cnt_reg <= '0;
      req_reg <= 1'b0;
      done_s_reg <= 1'b0;
      busy_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      done_s_reg <= done_s_next;
      busy_reg <= busy_next;
      seen_reg <= seen_next;
    end
  end

  assign LINK.reset_req = req_reg;
  assign BUSY = busy_reg;
  assign DONE_SEEN = seen_reg;
endmodule // urr_user

//--- urr_handshake_assertions.sv
// Assertions on the link between the two ends of the reset request handshake.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "urr_defines.svh"
module urr_handshake_assertions #(
  parameter int CAL_CYC = `URR_CAL_CYC,
  parameter int SEQ_CYC = `URR_SEQ_CYC
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic reset_req,
  input wire logic reset_done,
  input wire logic core_reset_n,
  input wire logic afi_reset_n
);
  localparam int CAL_HI = CAL_CYC + 1;
  localparam int SEQ_LO = SEQ_CYC - 1;
  localparam int SEQ_HI = SEQ_CYC + 1;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Cycles since the request last fell, saturating so old falls never look fresh.
  logic req_d_reg, req_d_next;
  logic [3:0] since_fall_reg, since_fall_next;
  always_comb begin
    req_d_next = reset_req;
    since_fall_next = (since_fall_reg == 4'hF) ? 4'hF : since_fall_reg + 4'h1;
    if (req_d_reg && !reset_req) since_fall_next = 4'h1;
  end
  always_ff @(posedge CLOCK) begin
    req_d_reg <= RST_N ? req_d_next : 1'b0;
    since_fall_reg <= RST_N ? since_fall_next : 4'hF;
  end
  property p_req_ready; $rose(reset_req) |-> reset_done; endproperty
  a_req_ready: assert property (p_req_ready) else $error("request while busy");
  property p_held; reset_req && reset_done |=> reset_done; endproperty
  a_held: assert property (p_held) else $error("held request acted on");
  property p_accept; $fell(reset_req) && reset_done |-> ##[1:6] !reset_done; endproperty
  a_accept: assert property (p_accept) else $error("done did not fall");
  property p_cause; $fell(reset_done) |-> since_fall_reg inside {[4'h1:4'h6]}; endproperty
  a_cause: assert property (p_cause) else $error("done fell without request");
  property p_rst; core_reset_n == afi_reset_n && (core_reset_n || !reset_done); endproperty
  a_rst: assert property (p_rst) else $error("core resets mismatch");
  property p_seq; $fell(core_reset_n) |-> ##[SEQ_LO:SEQ_HI] $rose(reset_done); endproperty
  a_seq: assert property (p_seq) else $error("sequence length wrong");
  property p_end; $rose(reset_done) |-> $rose(core_reset_n); endproperty
  a_end: assert property (p_end) else $error("done rose alone");
  property p_cal; $rose(RST_N) |-> ##[1:CAL_HI] reset_done; endproperty
  a_cal: assert property (p_cal) else $error("first calibration slow");
  c_fall: cover property ($fell(reset_done));
  c_rise: cover property ($rose(reset_done));
  c_seq: cover property ($fell(core_reset_n));
endmodule // urr_handshake_assertions

//--- user_reset_request_handshake_bench.sv
// Self-checking bench joining both ends, plus a second device driven directly.
// Assumes the package, interface, design and checker files compile first.
`timescale 1ns/1ps
module user_reset_request_handshake_bench;
  logic CLOCK, RST_N, start, others_done, cal_pass, req_b, busy, cal_ok, cal_bad, done_seen;
  int errors, checked;
  logic [1:0] exp_q[$];
  urr_if link();
  urr_if link_b();
  assign link_b.reset_req = req_b;
  urr_device i_urr_device (.CLOCK(CLOCK),
    .RST_N(RST_N), .LINK(link), .CAL_PASS_IN(cal_pass), .CAL_SUCCESS(cal_ok), .CAL_FAIL(cal_bad));
  urr_device i_urr_device_b (.CLOCK(CLOCK),
    .RST_N(RST_N), .LINK(link_b), .CAL_PASS_IN(cal_pass), .CAL_SUCCESS(), .CAL_FAIL());
  urr_user i_urr_user (.CLOCK(CLOCK), .RST_N(RST_N), .LINK(link), .START(start),
    .OTHERS_DONE(others_done), .BUSY(busy), .DONE_SEEN(done_seen));
  urr_handshake_assertions i_urr_handshake_assertions (.CLOCK(CLOCK), .RST_N(RST_N),
    .reset_req(link.reset_req), .reset_done(link.reset_done),
    .core_reset_n(link.core_reset_n), .afi_reset_n(link.afi_reset_n));
  task automatic cmp_cal(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_level(input logic got, input logic exp);
    cmp_cal({1'b0, got}, {1'b0, exp});
  endtask
  task automatic wrap_up();
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 200 && busy !== lvl; k++) @(negedge CLOCK);
    cmp_level(busy, lvl);
  endtask
  initial begin
    CLOCK = 0;
    forever #20 CLOCK = ~CLOCK;
  end
  // Generous span; every wait in the test is bounded well inside it, so a hang fails a check first.
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  always @(negedge busy) begin
    if (RST_N) cmp_cal({cal_ok, cal_bad}, exp_q.pop_front());
  end
  initial begin
    RST_N = 0;
    start = 0;
    others_done = 1;
    cal_pass = 0;
    req_b = 0;
    void'($urandom(7281));
    repeat (10) @(negedge CLOCK);
    RST_N = 1;
    // Done comes up after the first calibration; request only once it is high.
    repeat (20) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b1);
    req_b = 1;
    repeat (20) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b1);
    req_b = 0;
    repeat (6) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b0);
    req_b = 1;
    repeat (2) @(negedge CLOCK);
    req_b = 0;
    repeat (12) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b0);
    repeat (25) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b1);
    repeat (15) @(negedge CLOCK);
    cmp_level(link_b.reset_done, 1'b1);
    others_done = 0;
    start = 1;
    repeat (15) @(negedge CLOCK);
    cmp_level(busy, 1'b0);
    for (int i = 0; i < 6; i++) begin
      cal_pass = 1'($urandom % 2);
      exp_q.push_back(cal_pass ? 2'h2 : 2'h1);
      others_done = 1;
      start = 1;
      wait_busy(1'b1);
      start = i[0];
      wait_busy(1'b0);
      cmp_level(done_seen, 1'b1);
    end
    repeat (5) @(negedge CLOCK);
    cmp_level(1'(exp_q.size() == 0), 1'b1);
    wrap_up();
  end
endmodule // user_reset_request_handshake_bench
